/* tb/ccsc_top_asserts.sv */
// Concurrent checks on the ports of the clock source configuration block.
module ccsc_top_asserts
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        custom_clock_enable,
    input wire logic        first_port_controller_select,
    input wire logic        loop_demand,
    input wire logic [5:0]  second_port_rate_code,
    input wire logic        second_port_rate_auto,
    input wire logic        second_port_rate_tolerance,
    input wire logic [2:0]  second_port_tol_pct,
    input wire logic        loop_off,
    input wire logic        fractional_loop_permit,
    input wire logic [2:0]  input_clock_select,
    input wire logic [2:0]  active_clock_source,
    input wire logic        ratio_edge_falling,
    input wire logic        loop_run
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain, so clocking and reset are given once for all checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_RATE_AUTO: assert property (
        second_port_rate_auto == (second_port_rate_code == 6'h00))
        else $error("auto flag does not follow rate code zero");
    AST_RATE_MAX: assert property (second_port_rate_code <= 6'h28)
        else $error("rate code beyond defined range");
    AST_TOL: assert property (
        second_port_tol_pct == (second_port_rate_tolerance ? 3'h5 : 3'h1))
        else $error("tolerance percent wrong");
    AST_RSV_RD: assert property (
        clk_en && reg_addr == 8'h34 |=> reg_rdata[5:4] == 2'b00)
        else $error("reserved source bits read nonzero");
    AST_WR_SRC: assert property (
        clk_en && reg_wr && reg_addr == 8'h34 |=>
        loop_off == $past(reg_wdata[7]) && fractional_loop_permit == $past(reg_wdata[6])
        && ratio_edge_falling == $past(reg_wdata[0]))
        else $error("source register write lost");
    AST_LOOP_RUN: assert property (
        clk_en |=> loop_run == (!$past(loop_off) &&
        ($past(custom_clock_enable) || $past(loop_demand))))
        else $error("loop run wrong");
    AST_FIXED: assert property (
        clk_en |=> active_clock_source == (($past(input_clock_select) == 3'h4
        && !$past(first_port_controller_select)) ? 3'h0 : $past(input_clock_select)))
        else $error("active source wrong");
    AST_SRC_MAX: assert property (input_clock_select <= 3'h5)
        else $error("source select reserved");
    AST_HOLD: assert property (
        clk_en && reg_wr && reg_addr == 8'h33 && reg_wdata[7:2] > 6'h28
        |=> $stable(second_port_rate_code))
        else $error("reserved rate code taken");
    AST_HOLD_SRC: assert property (
        clk_en && reg_wr && reg_addr == 8'h34 && reg_wdata[3:1] > 3'h5
        |=> $stable(input_clock_select))
        else $error("reserved source code taken");

    // Main scenarios that the bench is expected to reach.
    COV_RSV: cover property (clk_en && reg_wr && reg_addr == 8'h33 && reg_wdata[7:2] > 6'h28);
    COV_RSV_SRC: cover property (clk_en && reg_wr && reg_addr == 8'h34 && reg_wdata[3:1] > 3'h5);
    COV_FIX: cover property (input_clock_select == 3'h4 && !first_port_controller_select);
    COV_RUN: cover property ($rose(loop_run));
endmodule

bind ccsc_top ccsc_top_asserts u_asserts (
    .clk                          (clk),
    .reset_n                      (reset_n),
    .clk_en                       (clk_en),
    .reg_wr                       (reg_wr),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_rdata                    (reg_rdata),
    .custom_clock_enable          (custom_clock_enable),
    .first_port_controller_select (first_port_controller_select),
    .loop_demand                  (loop_demand),
    .second_port_rate_code        (second_port_rate_code),
    .second_port_rate_auto        (second_port_rate_auto),
    .second_port_rate_tolerance   (second_port_rate_tolerance),
    .second_port_tol_pct          (second_port_tol_pct),
    .loop_off                     (loop_off),
    .fractional_loop_permit       (fractional_loop_permit),
    .input_clock_select           (input_clock_select),
    .active_clock_source          (active_clock_source),
    .ratio_edge_falling           (ratio_edge_falling),
    .loop_run                     (loop_run)
);

/* tb/ccsc_top_tb_top.sv */
// Self-checking testbench for the clock source configuration block.
module ccsc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, clk_en, reg_wr, custom_clock_enable, loop_demand;
    logic        first_port_controller_select, second_port_rate_tolerance, second_port_rate_auto;
    logic        loop_off, loop_run, fractional_loop_permit, ratio_edge_falling;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [5:0]  second_port_rate_code;
    logic [19:0] second_port_rate_typ_hz, second_port_rate_lo_hz, second_port_rate_hi_hz;
    logic [2:0]  second_port_tol_pct, input_clock_select, active_clock_source;
    int          errors, checks_done;

    ccsc_top uut (
        .clk                          (clk),
        .reset_n                      (reset_n),
        .clk_en                       (clk_en),
        .reg_wr                       (reg_wr),
        .reg_addr                     (reg_addr),
        .reg_wdata                    (reg_wdata),
        .reg_rdata                    (reg_rdata),
        .custom_clock_enable          (custom_clock_enable),
        .first_port_controller_select (first_port_controller_select),
        .loop_demand                  (loop_demand),
        .second_port_rate_code        (second_port_rate_code),
        .second_port_rate_tolerance   (second_port_rate_tolerance),
        .second_port_rate_auto        (second_port_rate_auto),
        .second_port_rate_typ_hz      (second_port_rate_typ_hz),
        .second_port_rate_lo_hz       (second_port_rate_lo_hz),
        .second_port_rate_hi_hz       (second_port_rate_hi_hz),
        .second_port_tol_pct          (second_port_tol_pct),
        .loop_off                     (loop_off),
        .fractional_loop_permit       (fractional_loop_permit),
        .input_clock_select           (input_clock_select),
        .active_clock_source          (active_clock_source),
        .ratio_edge_falling           (ratio_edge_falling),
        .loop_run                     (loop_run)
    );

    // Free running 25 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compares one value with its expectation and counts the outcome.
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // One write, plus a spare edge so the lagging outputs have settled.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Read data is registered, so it is taken one edge after the address.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        chk(nm, reg_rdata, exp);
    endtask

    task automatic t_rate();
        logic [5:0]  c [4]   = '{6'h00, 6'h01, 6'h14, 6'h28};
        logic [19:0] typ [4] = '{20'd0, 20'd768000, 20'd48000, 20'd3000};
        logic [19:0] lo [4]  = '{20'd0, 20'd670320, 20'd41895, 20'd2618};
        logic [19:0] hi [4]  = '{20'd0, 20'd791040, 20'd49440, 20'd3090};
        rd(8'h33, 8'h00, "rate rst");
        rd(8'h34, 8'h40, "src rst");
        rd(8'h50, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h33, {c[i], i[0], 1'b1});
            chk("code", second_port_rate_code, c[i]);
            chk("auto", second_port_rate_auto, i == 0);
            chk("tolbit", second_port_rate_tolerance, i[0]);
            chk("tol", second_port_tol_pct, i[0] ? 3'h5 : 3'h1);
            chk("typ", second_port_rate_typ_hz, typ[i]);
            chk("lo", second_port_rate_lo_hz, lo[i]);
            chk("hi", second_port_rate_hi_hz, hi[i]);
            rd(8'h33, {c[i], i[0], 1'b0}, "rate rd");
        end
        wr(8'h33, 8'ha4);
        chk("code 41", second_port_rate_code, 6'h28);
        chk("typ 41", second_port_rate_typ_hz, 20'd3000);
        wr(8'h33, 8'hfe);
        chk("code 63", second_port_rate_code, 6'h28);
        rd(8'h33, 8'hfe, "rsv rd");
        $display("test rate done");
    endtask

    task automatic t_src();
        logic [2:0] s;
        logic [2:0] v;
        v = 3'h0;
        for (int j = 0; j < 16; j++)
        begin
            s = j[2:0];
            first_port_controller_select <= j[3];
            wr(8'h34, {j[0], !j[0], 2'b11, s, j[1]});
            v = (s > 3'h5) ? v : s;
            chk("sel", input_clock_select, v);
            chk("act", active_clock_source, (v == 3'h4 && !j[3]) ? 3'h0 : v);
            chk("bits", {loop_off, fractional_loop_permit, ratio_edge_falling},
                {j[0], !j[0], j[1]});
            rd(8'h34, {j[0], !j[0], 2'b00, s, j[1]}, "src rd");
        end
        $display("test source done");
    endtask

    task automatic t_loop();
        for (int k = 0; k < 8; k++)
        begin
            custom_clock_enable <= k[1];
            loop_demand         <= k[0];
            wr(8'h34, {k[2], 7'h40});
            chk("run", loop_run, !k[2] && (k[1] || k[0]));
        end
        clk_en <= 1'b0;
        wr(8'h34, 8'h00);
        chk("frozen", loop_off, 1'b1);
        clk_en <= 1'b1;
        $display("test loop done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The whole sequence needs well under 1000 cycles; a hang is cut at 4000.
    initial
    begin
        repeat (4000) @(posedge clk);
        errors++;
        wrap_up();
    end

    // Reset for six cycles, then the scenarios in turn.
    initial
    begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        custom_clock_enable = 1'b0;
        first_port_controller_select = 1'b0;
        loop_demand = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_rate();
        t_src();
        t_loop();
        wrap_up();
    end
endmodule

/* verilog/ccsc_pkg.sv */
// Package with register map, field layout, reset values and encodings for clock source config.
package ccsc_pkg;

    // Register offsets on the control port.
    localparam logic [7:0] CCSC_RATE_OFS     = 8'h33;
    localparam logic [7:0] CCSC_SRC_OFS      = 8'h34;

    // Reset values.
    localparam logic [7:0] CCSC_RATE_RESET   = 8'h00;
    localparam logic [7:0] CCSC_SRC_RESET    = 8'h40;

    // Secondary rate register fields.
    localparam int         CCSC_RATE_CODE_HI = 7;
    localparam int         CCSC_RATE_CODE_LO = 2;
    localparam int         CCSC_RATE_TOL_BIT = 1;
    localparam logic [5:0] CCSC_RATE_AUTO    = 6'h00;
    localparam logic [5:0] CCSC_RATE_MAX     = 6'h28;

    // Source and loop register fields.
    localparam int         CCSC_LOOP_OFF_BIT = 7;
    localparam int         CCSC_FRAC_BIT     = 6;
    localparam int         CCSC_SEL_HI       = 3;
    localparam int         CCSC_SEL_LO       = 1;
    localparam int         CCSC_EDGE_BIT     = 0;

    // Tolerance settings in percent.
    localparam logic [2:0] CCSC_TOL_NARROW   = 3'h1;
    localparam logic [2:0] CCSC_TOL_WIDE     = 3'h5;

    // Input clock source encodings.
    typedef enum logic [2:0] {
        CCSC_SRC_P_BCLK  = 3'h0,
        CCSC_SRC_P_FSYNC = 3'h1,
        CCSC_SRC_S_BCLK  = 3'h2,
        CCSC_SRC_S_FSYNC = 3'h3,
        CCSC_SRC_FIXED   = 3'h4,
        CCSC_SRC_OSC     = 3'h5
    } ccsc_src_t;

endpackage

/* verilog/ccsc_rate_if.sv */
// Interface carrying the decoded secondary rate selection between modules.
interface ccsc_rate_if;
    logic [5:0]  code;
    logic        tol_wide;
    logic        auto_mode;
    logic [19:0] typ_hz;
    logic [19:0] lo_hz;
    logic [19:0] hi_hz;
    logic [2:0]  tol_pct;

    modport regs (output code, output tol_wide, input auto_mode, input typ_hz,
                  input lo_hz, input hi_hz, input tol_pct);
    modport dec  (input code, input tol_wide, output auto_mode, output typ_hz,
                  output lo_hz, output hi_hz, output tol_pct);
endinterface

/* verilog/ccsc_rate_table.sv */
// Rate code lookup giving typical rate and acceptance range for the secondary port.
module ccsc_rate_table
    import ccsc_pkg::*;
(
    ccsc_rate_if.dec rate
);

    // Table of typical, low and high rates in Hz for each defined code.
    function automatic logic [59:0] ccsc_lookup(input logic [5:0] c);
        case (c)
            6'h01:   ccsc_lookup = {20'd768000, 20'd670320, 20'd791040};
            6'h02:   ccsc_lookup = {20'd614400, 20'd536256, 20'd632832};
            6'h03:   ccsc_lookup = {20'd512000, 20'd446880, 20'd527360};
            6'h04:   ccsc_lookup = {20'd438857, 20'd383040, 20'd452022};
            6'h05:   ccsc_lookup = {20'd384000, 20'd335160, 20'd395520};
            6'h06:   ccsc_lookup = {20'd341333, 20'd297920, 20'd351573};
            6'h07:   ccsc_lookup = {20'd307200, 20'd268128, 20'd316416};
            6'h08:   ccsc_lookup = {20'd256000, 20'd223440, 20'd263680};
            6'h09:   ccsc_lookup = {20'd219429, 20'd191520, 20'd226011};
            6'h0a:   ccsc_lookup = {20'd192000, 20'd167580, 20'd197760};
            6'h0b:   ccsc_lookup = {20'd170667, 20'd148960, 20'd175786};
            6'h0c:   ccsc_lookup = {20'd153600, 20'd134064, 20'd158208};
            6'h0d:   ccsc_lookup = {20'd128000, 20'd111720, 20'd131840};
            6'h0e:   ccsc_lookup = {20'd109714, 20'd95760, 20'd113005};
            6'h0f:   ccsc_lookup = {20'd96000, 20'd83790, 20'd98880};
            6'h10:   ccsc_lookup = {20'd85333, 20'd74480, 20'd87893};
            6'h11:   ccsc_lookup = {20'd76800, 20'd67032, 20'd79104};
            6'h12:   ccsc_lookup = {20'd64000, 20'd55860, 20'd65920};
            6'h13:   ccsc_lookup = {20'd54857, 20'd47880, 20'd56502};
            6'h14:   ccsc_lookup = {20'd48000, 20'd41895, 20'd49440};
            6'h15:   ccsc_lookup = {20'd42667, 20'd37240, 20'd43946};
            6'h16:   ccsc_lookup = {20'd38400, 20'd33516, 20'd39552};
            6'h17:   ccsc_lookup = {20'd32000, 20'd27930, 20'd32960};
            6'h18:   ccsc_lookup = {20'd27429, 20'd23940, 20'd28251};
            6'h19:   ccsc_lookup = {20'd24000, 20'd20947, 20'd24720};
            6'h1a:   ccsc_lookup = {20'd21333, 20'd18620, 20'd21973};
            6'h1b:   ccsc_lookup = {20'd19200, 20'd16758, 20'd19776};
            6'h1c:   ccsc_lookup = {20'd16000, 20'd13965, 20'd16480};
            6'h1d:   ccsc_lookup = {20'd13714, 20'd11970, 20'd14125};
            6'h1e:   ccsc_lookup = {20'd12000, 20'd10473, 20'd12360};
            6'h1f:   ccsc_lookup = {20'd10667, 20'd9310, 20'd10986};
            6'h20:   ccsc_lookup = {20'd9600, 20'd8379, 20'd9888};
            6'h21:   ccsc_lookup = {20'd8000, 20'd6982, 20'd8240};
            6'h22:   ccsc_lookup = {20'd6857, 20'd5985, 20'd7062};
            6'h23:   ccsc_lookup = {20'd6000, 20'd5236, 20'd6180};
            6'h24:   ccsc_lookup = {20'd5333, 20'd4655, 20'd5493};
            6'h25:   ccsc_lookup = {20'd4800, 20'd4189, 20'd4944};
            6'h26:   ccsc_lookup = {20'd4000, 20'd3491, 20'd4120};
            6'h27:   ccsc_lookup = {20'd3429, 20'd2992, 20'd3531};
            6'h28:   ccsc_lookup = {20'd3000, 20'd2618, 20'd3090};
            default: ccsc_lookup = 60'h0;
        endcase
    endfunction

    // Auto code reports zero rates; the detector then owns the figure.
    always_comb
    begin
        {rate.typ_hz, rate.lo_hz, rate.hi_hz} = ccsc_lookup(rate.code);
        rate.auto_mode = (rate.code == CCSC_RATE_AUTO);
        rate.tol_pct   = rate.tol_wide ? CCSC_TOL_WIDE : CCSC_TOL_NARROW;
    end

endmodule

/* verilog/ccsc_top.sv */
// Clock source and secondary rate configuration registers with decoded controls.
// Operation
// - Bits 7:2 of the rate register hold the secondary rate code, zero meaning auto detect.
// - Codes 1 to 40 pick one fixed rate and range from 768000 Hz down to 3000 Hz; 41-63 reserved.
// - The tolerance bit picks 1% auto-detect tolerance when clear and 5% when set.
// - Reserved bits read as zero and software writes them only as zero.
// - Loop-off bit clear runs the loop always in custom mode or on demand in auto; set stops it.
// - Bit 6, reset one, permits fractional loop operation; clear restricts to integer mode.
// - Bits 3:1 choose the input clock among six sources, with codes 6 and 7 reserved.
// - The fixed external clock source is used only when the device is in controller mode.
// - Bit 0 of the source register picks rising (0) or falling (1) edge for ratio detection.
// - A custom-clock bit picks automatic configuration when clear and manual when set.
// - A port bit puts the first port in target mode when clear and controller mode when set.
//
// Both registers sit on a plain write-strobe port with registered read data. Decoded outputs
// follow defined codes only, while the raw registers read back what was written, apart from
// the reserved bits, which are cleared on the way in. The clock enable freezes every flop,
// readback included, so a stalled bus never sees its data move.
module ccsc_top
    import ccsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        custom_clock_enable,
    input  wire logic        first_port_controller_select,
    input  wire logic        loop_demand,
    output logic      [5:0]  second_port_rate_code,
    output logic             second_port_rate_tolerance,
    output logic             second_port_rate_auto,
    output logic      [19:0] second_port_rate_typ_hz,
    output logic      [19:0] second_port_rate_lo_hz,
    output logic      [19:0] second_port_rate_hi_hz,
    output logic      [2:0]  second_port_tol_pct,
    output logic             loop_off,
    output logic             fractional_loop_permit,
    output logic      [2:0]  input_clock_select,
    output logic      [2:0]  active_clock_source,
    output logic             ratio_edge_falling,
    output logic             loop_run
);

    // Software-visible register contents.
    logic [7:0] rate_reg_q;
    logic [7:0] rate_reg_d;
    logic [7:0] src_reg_q;
    logic [7:0] src_reg_d;
    // Last valid selections, kept apart so a reserved code never reaches the clock path.
    logic [5:0] rate_valid_q;
    logic [5:0] rate_valid_d;
    logic [2:0] src_valid_q;
    logic [2:0] src_valid_d;
    // Registered data outputs.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       run_q;
    logic       run_d;
    logic [2:0] active_q;
    logic [2:0] active_d;

    // Decoded rate selection shared with the table lookup. The table sees only the last
    // valid code, so a reserved write leaves the reported rate and its range untouched.
    ccsc_rate_if rate_bus ();

    // Mask that clears reserved bits so they always read back as zero.
    function automatic logic [7:0] ccsc_mask(input logic [7:0] a, input logic [7:0] v);
        if (a == CCSC_RATE_OFS)
            ccsc_mask = v & 8'hfe;
        else
            ccsc_mask = v & 8'hcf;
    endfunction

    // A source code is defined only up to the internal oscillator; codes 6 and 7 lie
    // outside the encoding and are refused.
    function automatic logic ccsc_src_ok(input logic [2:0] s);
        ccsc_src_ok = (s <= CCSC_SRC_OSC);
    endfunction

    // Write hits, decoded once so that every group below agrees on what was written.
    // Any other offset is ignored, so stray writes cannot disturb the clock setup.
    logic rate_hit;
    logic src_hit;
    assign rate_hit = reg_wr && (reg_addr == CCSC_RATE_OFS);
    assign src_hit  = reg_wr && (reg_addr == CCSC_SRC_OFS);

    // Software-visible contents; reserved bits are cleared on the way in.
    always_comb
    begin
        rate_reg_d = rate_reg_q;
        src_reg_d  = src_reg_q;
        if (rate_hit)
            rate_reg_d = ccsc_mask(CCSC_RATE_OFS, reg_wdata);
        if (src_hit)
            src_reg_d = ccsc_mask(CCSC_SRC_OFS, reg_wdata);
    end

    // Register group; writes are taken only on enabled edges.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rate_reg_q <= CCSC_RATE_RESET;
            src_reg_q  <= CCSC_SRC_RESET;
        end
        else if (clk_en)
        begin
            rate_reg_q <= rate_reg_d;
            src_reg_q  <= src_reg_d;
        end
    end

    // Last valid selections. A reserved code stays in the raw register so that software
    // reads back what it wrote, but it never reaches the clock path.
    always_comb
    begin
        rate_valid_d = rate_valid_q;
        src_valid_d  = src_valid_q;
        if (rate_hit && reg_wdata[CCSC_RATE_CODE_HI:CCSC_RATE_CODE_LO] <= CCSC_RATE_MAX)
            rate_valid_d = reg_wdata[CCSC_RATE_CODE_HI:CCSC_RATE_CODE_LO];
        if (src_hit && ccsc_src_ok(reg_wdata[CCSC_SEL_HI:CCSC_SEL_LO]))
            src_valid_d = reg_wdata[CCSC_SEL_HI:CCSC_SEL_LO];
    end

    // Valid-selection group; reset puts auto rate detection and the primary bit clock
    // in force. Keeping these apart costs nine flops but keeps readback faithful.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rate_valid_q <= CCSC_RATE_AUTO;
            src_valid_q  <= CCSC_SRC_P_BCLK;
        end
        else if (clk_en)
        begin
            rate_valid_q <= rate_valid_d;
            src_valid_q  <= src_valid_d;
        end
    end

    // Readback multiplexer; unmapped offsets read as zero rather than echoing a register,
    // so software can tell a wrong offset from a live one.
    always_comb
    begin
        case (reg_addr)
            CCSC_RATE_OFS: rdata_d = rate_reg_q;
            CCSC_SRC_OFS:  rdata_d = src_reg_q;
            default:       rdata_d = 8'h00;
        endcase
    end

    // Readback register; data lags the address by one enabled edge, which keeps the
    // multiplexer out of the output timing path.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 8'h00;
        else if (clk_en)
            rdata_q <= rdata_d;
    end

    // Effective source and loop state. The fixed clock falls back to the primary bit clock
    // outside controller mode, since without a controller there is no ratio set up for it.
    // The loop demand level comes from logic on this same clock, so it needs no
    // synchroniser; it only matters in automatic configuration.
    always_comb
    begin
        active_d = src_valid_q;
        if (src_valid_q == CCSC_SRC_FIXED && !first_port_controller_select)
            active_d = CCSC_SRC_P_BCLK;
        if (src_reg_q[CCSC_LOOP_OFF_BIT])
            run_d = 1'b0;
        else if (custom_clock_enable)
            run_d = 1'b1;
        else
            run_d = loop_demand;
    end

    // Loop and source output group; both lag the selection by one enabled edge, which a
    // user must allow for before switching clocks downstream.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_q    <= 1'b0;
            active_q <= CCSC_SRC_P_BCLK;
        end
        else if (clk_en)
        begin
            run_q    <= run_d;
            active_q <= active_d;
        end
    end

    // Rate decode uses only the last valid code.
    assign rate_bus.code     = rate_valid_q;
    assign rate_bus.tol_wide = rate_reg_q[CCSC_RATE_TOL_BIT];

    ccsc_rate_table u_rate_table (
        .rate (rate_bus.dec)
    );

    // Output mapping. Every output comes straight from a flop or from the table lookup
    // on a flopped code, so nothing here depends on the bus inputs of the same cycle.
    // The tolerance bit is reported raw, since it is meaningful even for reserved codes.
    assign reg_rdata                  = rdata_q;
    assign second_port_rate_code      = rate_valid_q;
    assign second_port_rate_tolerance = rate_reg_q[CCSC_RATE_TOL_BIT];
    assign second_port_rate_auto      = rate_bus.auto_mode;
    assign second_port_rate_typ_hz    = rate_bus.typ_hz;
    assign second_port_rate_lo_hz     = rate_bus.lo_hz;
    assign second_port_rate_hi_hz     = rate_bus.hi_hz;
    assign second_port_tol_pct        = rate_bus.tol_pct;
    assign loop_off                   = src_reg_q[CCSC_LOOP_OFF_BIT];
    assign fractional_loop_permit     = src_reg_q[CCSC_FRAC_BIT];
    assign input_clock_select         = src_valid_q;
    assign active_clock_source        = active_q;
    assign ratio_edge_falling         = src_reg_q[CCSC_EDGE_BIT];
    assign loop_run                   = run_q;

endmodule
